// ===== common/tppl_pkg.sv
package tppl_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int          TPPL_ADDR_W   = 18;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_POL_ONE   = 16'h2007;
  localparam logic [15:0] IDX_POL_TWO   = 16'h20F7;
  localparam logic [15:0] IDX_CTRL      = 16'h60B8;
  localparam logic [15:0] IDX_STAT      = 16'h60B9;
  localparam logic [15:0] IDX_POS_1R    = 16'h60BA;
  localparam logic [15:0] IDX_POS_1F    = 16'h60BB;
  localparam logic [15:0] IDX_POS_2R    = 16'h60BC;
  localparam logic [15:0] IDX_POS_2F    = 16'h60BD;
  localparam logic [15:0] IDX_CNT_1R    = 16'h60D5;
  localparam logic [15:0] IDX_CNT_1F    = 16'h60D6;
  localparam logic [15:0] IDX_CNT_2R    = 16'h60D7;
  localparam logic [15:0] IDX_CNT_2F    = 16'h60D8;
  localparam logic [15:0] IDX_DIG_IN    = 16'h60FD;
  localparam logic [15:0] IDX_IRQ_STAT  = 16'h6100;
  localparam logic [15:0] IDX_IRQ_MASK  = 16'h6101;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          PROBE_STRIDE  = 8;
  localparam int          CB_EN         = 0;
  localparam int          CB_MODE       = 1;
  localparam int          CB_SRC        = 2;
  localparam int          CB_RISE       = 4;
  localparam int          CB_FALL       = 5;
  localparam logic [7:0]  CFG_MASK      = 8'h35;
  localparam int          SB_RISE       = 1;
  localparam int          SB_FALL       = 2;
  localparam int          DIG_A_BIT     = 26;
  localparam int          DIG_B_BIT     = 27;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_POL       = 16'h0001;
  localparam logic [15:0] RST_CTRL      = 16'h0000;
  localparam logic [3:0]  RST_IRQ_MASK  = 4'h0;

  // ----------------------------------------------------------------
  // Whole state of the block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0]      ctrl;
    logic [15:0]      pol1;
    logic [15:0]      pol2;
    logic [2:0]       meta;
    logic [2:0]       sync;
    logic [1:0]       prev;
    logic [1:0]       chg;
    logic [3:0]       done;
    logic [3:0][31:0] pos;
    logic [3:0][31:0] cnt;
    logic [3:0]       ist;
    logic [3:0]       mask;
    logic             irq;
    logic             awready;
    logic             aw_held;
    logic [15:0]      aw_idx;
    logic             wready;
    logic             w_held;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } tppl_state_t;

endpackage

// ===== rtl/tppl_probe_latch.sv
`timescale 1ns/1ps

// Summary of operation
// - Polarity bits 0/1 condition inputs A/B
// - Control low byte probe one, high two
// - Single-shot: only rising edge is valid
// - Continuous: rising and falling edges valid
// - Enable, source or edge-enable change clears counters and status
// - Input levels shown at bits 26, 27
// - Bits 1/9 pick single or continuous
// - Bits 2/10 pick input or index
// - Bits 4,5/12,13 enable rise, fall
// - Probe one status bits 1, 2 executed
// - Probe two status bits 9, 10 executed
// - Accepted edge stores signed position
// - Continuous keeps value until next trigger
module tppl_probe_latch
  import tppl_pkg::*;
(
  // Clock and reset
  input  wire logic                   I_SYS_CLK,
  input  wire logic                   I_RST_B,
  // Probe sources
  input  wire logic                   I_TOUCH_INPUT_A,
  input  wire logic                   I_TOUCH_INPUT_B,
  input  wire logic                   I_ENC_INDEX,
  input  wire logic [31:0]            I_POSITION,
  // AXI4-Lite write
  input  wire logic                   I_AWVALID,
  output logic                        O_AWREADY,
  input  wire logic [TPPL_ADDR_W-1:0] I_AWADDR,
  input  wire logic                   I_WVALID,
  output logic                        O_WREADY,
  input  wire logic [31:0]            I_WDATA,
  input  wire logic [3:0]             I_WSTRB,
  output logic                        O_BVALID,
  input  wire logic                   I_BREADY,
  output logic [1:0]                  O_BRESP,
  // AXI4-Lite read
  input  wire logic                   I_ARVALID,
  output logic                        O_ARREADY,
  input  wire logic [TPPL_ADDR_W-1:0] I_ARADDR,
  output logic                        O_RVALID,
  input  wire logic                   I_RREADY,
  output logic [31:0]                 O_RDATA,
  output logic [1:0]                  O_RRESP,
  // Interrupt
  output logic                        O_IRQ
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic reg_hit(input logic [15:0] idx);
    case (idx)
      IDX_POL_ONE, IDX_POL_TWO, IDX_CTRL, IDX_STAT,
      IDX_POS_1R, IDX_POS_1F, IDX_POS_2R, IDX_POS_2F,
      IDX_CNT_1R, IDX_CNT_1F, IDX_CNT_2R, IDX_CNT_2F,
      IDX_DIG_IN, IDX_IRQ_STAT, IDX_IRQ_MASK: reg_hit = 1'b1;
      default:                                reg_hit = 1'b0;
    endcase
  endfunction

  tppl_state_t st_q;
  tppl_state_t st_d;

  // ----------------------------------------------------------------
  // Write channel joining
  // ----------------------------------------------------------------
  logic        aw_take;
  logic        w_take;
  logic        aw_have;
  logic        w_have;
  logic        wr_go;
  logic [15:0] wr_idx;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic [15:0] rd_idx;
  logic        ar_take;
  logic [31:0] mrg_ctrl;
  logic [31:0] mrg_pol1;
  logic [31:0] mrg_pol2;
  logic [15:0] ctrl_nx;
  logic [31:0] stat_word;
  logic [31:0] dig_word;

  // Address and data may arrive in either order; the first one waits
  assign aw_take  = I_AWVALID & st_q.awready;
  assign w_take   = I_WVALID & st_q.wready;
  assign aw_have  = st_q.aw_held | aw_take;
  assign w_have   = st_q.w_held | w_take;
  assign wr_go    = aw_have & w_have & ~st_q.bvalid;
  assign wr_idx   = st_q.aw_held ? st_q.aw_idx : I_AWADDR[TPPL_ADDR_W-1:2];
  assign wr_data  = st_q.w_held ? st_q.w_data : I_WDATA;
  assign wr_strb  = st_q.w_held ? st_q.w_strb : I_WSTRB;
  assign rd_idx   = I_ARADDR[TPPL_ADDR_W-1:2];
  assign ar_take  = I_ARVALID & st_q.arready;
  assign mrg_ctrl = merge_bytes({16'h0000, st_q.ctrl}, wr_data, wr_strb);
  assign mrg_pol1 = merge_bytes({16'h0000, st_q.pol1}, wr_data, wr_strb);
  assign mrg_pol2 = merge_bytes({16'h0000, st_q.pol2}, wr_data, wr_strb);
  assign ctrl_nx  = (wr_go && wr_idx == IDX_CTRL) ? mrg_ctrl[15:0] : st_q.ctrl;

  // ----------------------------------------------------------------
  // Per-probe edge qualification
  // ----------------------------------------------------------------
  logic [1:0] src_lvl;
  logic [1:0] cfg_chg;
  logic [1:0] rise_ev;
  logic [1:0] fall_ev;
  logic [3:0] acc;

  for (genvar gp = 0; gp < 2; gp++) begin : g_probe
    localparam int B = gp * PROBE_STRIDE;
    // Index pulse bypasses the polarity setting
    assign src_lvl[gp] = st_q.ctrl[B+CB_SRC] ? st_q.sync[2]
                                             : (st_q.sync[gp] ~^ st_q.pol1[gp]);
    assign cfg_chg[gp] = |((ctrl_nx[B +: 8] ^ st_q.ctrl[B +: 8]) & CFG_MASK);
    // Source may just have switched: skip the cycle after a change
    assign rise_ev[gp] = src_lvl[gp] & ~st_q.prev[gp] & ~cfg_chg[gp] & ~st_q.chg[gp];
    assign fall_ev[gp] = ~src_lvl[gp] & st_q.prev[gp] & ~cfg_chg[gp] & ~st_q.chg[gp];
    // Single-shot takes only the first rising edge after enabling
    assign acc[2*gp]   = st_q.ctrl[B+CB_EN] & st_q.ctrl[B+CB_RISE] & rise_ev[gp]
                         & (st_q.ctrl[B+CB_MODE] | ~st_q.done[2*gp]);
    assign acc[2*gp+1] = st_q.ctrl[B+CB_EN] & st_q.ctrl[B+CB_FALL] & fall_ev[gp]
                         & st_q.ctrl[B+CB_MODE];
  end

  // ----------------------------------------------------------------
  // Readable words
  // ----------------------------------------------------------------
  always_comb begin
    stat_word                       = 32'h0000_0000;
    stat_word[CB_EN]                = st_q.ctrl[CB_EN];
    stat_word[PROBE_STRIDE+CB_EN]   = st_q.ctrl[PROBE_STRIDE+CB_EN];
    stat_word[SB_RISE]              = st_q.done[0];
    stat_word[SB_FALL]              = st_q.done[1];
    stat_word[PROBE_STRIDE+SB_RISE] = st_q.done[2];
    stat_word[PROBE_STRIDE+SB_FALL] = st_q.done[3];
    dig_word                        = 32'h0000_0000;
    dig_word[DIG_A_BIT]             = st_q.sync[0];
    dig_word[DIG_B_BIT]             = st_q.sync[1];
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    // Pin synchronisers; edge detection looks at the second stage only
    st_d.meta = {I_ENC_INDEX, I_TOUCH_INPUT_B, I_TOUCH_INPUT_A};
    st_d.sync = st_q.meta;
    st_d.prev = src_lvl;
    st_d.chg  = cfg_chg;
    st_d.ctrl = ctrl_nx;

    // Register writes
    if (aw_take) begin
      st_d.aw_idx = I_AWADDR[TPPL_ADDR_W-1:2];
    end
    if (w_take) begin
      st_d.w_data = I_WDATA;
      st_d.w_strb = I_WSTRB;
    end
    st_d.aw_held = aw_have & ~wr_go;
    st_d.w_held  = w_have & ~wr_go;
    if (st_q.bvalid && I_BREADY) begin
      st_d.bvalid = 1'b0;
    end
    if (wr_go) begin
      st_d.bvalid = 1'b1;
      st_d.bresp  = reg_hit(wr_idx) ? RESP_OKAY : RESP_SLVERR;
      case (wr_idx)
        IDX_POL_ONE:  st_d.pol1 = mrg_pol1[15:0];
        IDX_POL_TWO:  st_d.pol2 = mrg_pol2[15:0];
        IDX_IRQ_MASK: st_d.mask = wr_strb[0] ? wr_data[3:0] : st_q.mask;
        IDX_IRQ_STAT: st_d.ist  = st_q.ist & ~(wr_strb[0] ? wr_data[3:0] : 4'h0);
        default:      st_d.bresp = st_d.bresp;
      endcase
    end
    st_d.awready = ~st_d.aw_held & ~st_d.bvalid;
    st_d.wready  = ~st_d.w_held & ~st_d.bvalid;

    // Latching; a change of enable, source or edge enables wipes the probe's history
    for (int p = 0; p < 2; p++) begin
      if (cfg_chg[p]) begin
        st_d.cnt[2*p]      = 32'h0000_0000;
        st_d.cnt[2*p+1]    = 32'h0000_0000;
        st_d.done[2*p +: 2] = 2'h0;
      end
      for (int e = 0; e < 2; e++) begin
        if (acc[2*p+e]) begin
          st_d.pos[2*p+e]  = I_POSITION;
          st_d.cnt[2*p+e]  = st_q.cnt[2*p+e] + 32'h0000_0001;
          st_d.done[2*p+e] = 1'b1;
        end
      end
    end

    // Events win over a same-cycle write-one-to-clear
    st_d.ist = st_d.ist | acc;
    st_d.irq = |(st_d.ist & st_d.mask);

    // Register reads, one cycle after the address is taken
    if (st_q.rvalid && I_RREADY) begin
      st_d.rvalid = 1'b0;
    end
    if (ar_take) begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = reg_hit(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      case (rd_idx)
        IDX_POL_ONE:  st_d.rdata = {16'h0000, st_q.pol1};
        IDX_POL_TWO:  st_d.rdata = {16'h0000, st_q.pol2};
        IDX_CTRL:     st_d.rdata = {16'h0000, st_q.ctrl};
        IDX_STAT:     st_d.rdata = stat_word;
        IDX_POS_1R:   st_d.rdata = st_q.pos[0];
        IDX_POS_1F:   st_d.rdata = st_q.pos[1];
        IDX_POS_2R:   st_d.rdata = st_q.pos[2];
        IDX_POS_2F:   st_d.rdata = st_q.pos[3];
        IDX_CNT_1R:   st_d.rdata = st_q.cnt[0];
        IDX_CNT_1F:   st_d.rdata = st_q.cnt[1];
        IDX_CNT_2R:   st_d.rdata = st_q.cnt[2];
        IDX_CNT_2F:   st_d.rdata = st_q.cnt[3];
        IDX_DIG_IN:   st_d.rdata = dig_word;
        IDX_IRQ_STAT: st_d.rdata = {28'h000_0000, st_q.ist};
        IDX_IRQ_MASK: st_d.rdata = {28'h000_0000, st_q.mask};
        default:      st_d.rdata = 32'h0000_0000;
      endcase
    end
    st_d.arready = ~st_d.rvalid;

    if (!I_RST_B) begin
      st_d      = '0;
      st_d.ctrl = RST_CTRL;
      st_d.pol1 = RST_POL;
      st_d.pol2 = RST_POL;
      st_d.mask = RST_IRQ_MASK;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    st_q <= st_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign O_AWREADY = st_q.awready;
  assign O_WREADY  = st_q.wready;
  assign O_BVALID  = st_q.bvalid;
  assign O_BRESP   = st_q.bresp;
  assign O_ARREADY = st_q.arready;
  assign O_RVALID  = st_q.rvalid;
  assign O_RDATA   = st_q.rdata;
  assign O_RRESP   = st_q.rresp;
  assign O_IRQ     = st_q.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_B);

  a_polarity_invert: assert property (
    (!st_q.pol1[0] && !st_q.ctrl[CB_SRC] && $past(I_RST_B, 2)) |-> src_lvl[0] == !$past(I_TOUCH_INPUT_A, 2))
    else $error("probe one level ignores polarity");

  a_single_no_fall: assert property (
    $rose(st_q.done[1]) |-> $past(st_q.ctrl[CB_MODE]))
    else $error("falling latch taken in single-shot mode");

  a_single_once: assert property (
    (st_q.done[0] && !st_q.ctrl[CB_MODE] && !cfg_chg[0]) |=> $stable(st_q.pos[0]))
    else $error("single-shot relatched without rearm");

  a_cont_fall_count: assert property (
    (st_q.ctrl[CB_EN] && st_q.ctrl[CB_MODE] && st_q.ctrl[CB_FALL] && fall_ev[0])
    |=> st_q.cnt[1] == $past(st_q.cnt[1]) + 32'h0000_0001)
    else $error("continuous falling edge not counted");

  a_cfg_clears: assert property (
    cfg_chg[1] |=> (st_q.cnt[2] == 32'h0000_0000 && st_q.cnt[3] == 32'h0000_0000 && st_q.done[3:2] == 2'h0))
    else $error("config change left probe two history");

  a_level_report: assert property (
    ($stable(I_TOUCH_INPUT_B)[*3] ##0 $past(I_RST_B, 2)) |-> dig_word[DIG_B_BIT] == I_TOUCH_INPUT_B)
    else $error("input level bit stale");

  a_rise_gate: assert property (
    (!st_q.ctrl[PROBE_STRIDE+CB_RISE] && !cfg_chg[1]) |=> $stable(st_q.cnt[2]))
    else $error("rising latch without rising enable");

  a_status_set: assert property (
    $rose(st_q.done[2]) |-> $past(acc[2]))
    else $error("probe two rising status without latch");

  a_pos_capture: assert property (
    acc[3] |=> st_q.pos[3] == $past(I_POSITION))
    else $error("latched position mismatch");

  a_pos_hold: assert property (
    !acc[0] |=> $stable(st_q.pos[0]))
    else $error("latched position changed without trigger");

  a_irq_follow: assert property (
    (st_q.mask[0] && acc[0] && !wr_go) |=> O_IRQ)
    else $error("unmasked event did not raise interrupt");

  a_probe_split: assert property (
    (cfg_chg[0] && !cfg_chg[1] && !acc[2]) |=> $stable(st_q.cnt[2]))
    else $error("probe one config touched probe two");

  a_mode_select: assert property (
    $rose(st_q.done[3]) |-> $past(st_q.ctrl[PROBE_STRIDE+CB_MODE]))
    else $error("probe two falling latch outside continuous mode");

  a_index_source: assert property (
    (st_q.ctrl[PROBE_STRIDE+CB_SRC] && $past(I_RST_B, 2)) |-> src_lvl[1] == $past(I_ENC_INDEX, 2))
    else $error("probe two not following index pulse");

  a_rise_status: assert property (
    $rose(st_q.done[0]) |-> $past(acc[0]))
    else $error("probe one rising status without latch");

  a_fall_status: assert property (
    acc[1] |=> st_q.done[1])
    else $error("probe one falling status not set");

  a_cont_keep: assert property (
    (st_q.ctrl[PROBE_STRIDE+CB_MODE] && !acc[2]) |=> $stable(st_q.pos[2]))
    else $error("continuous latch changed without trigger");

  a_count_step: assert property (
    acc[2] |=> st_q.cnt[2] == $past(st_q.cnt[2]) + 32'h0000_0001)
    else $error("probe two rising latch not counted");

  a_status_enable: assert property (
    (ar_take && rd_idx == IDX_STAT) |=> O_RDATA[CB_EN] == $past(st_q.ctrl[CB_EN]))
    else $error("status enable bit differs from control");

  a_bresp_hold: assert property (
    (O_BVALID && !I_BREADY) |=> O_BVALID)
    else $error("write response dropped before accepted");

  a_rdata_hold: assert property (
    (O_RVALID && !I_RREADY) |=> (O_RVALID && $stable(O_RDATA)))
    else $error("read data changed before accepted");

  a_irq_level: assert property (
    O_IRQ == |(st_q.ist & st_q.mask))
    else $error("interrupt level differs from masked status");

  a_read_error: assert property (
    (ar_take && !reg_hit(rd_idx)) |=> O_RRESP == RESP_SLVERR)
    else $error("unmapped read not refused");

endmodule

// ===== test/tppl_sensor_model.sv
`timescale 1ns/1ps

// --------------------
// Probe sensors and encoder index
// --------------------
module tppl_sensor_model (
  // Clock
  input  wire logic        i_clk,
  // Sensor lines
  output logic             o_touch_a,
  output logic             o_touch_b,
  output logic             o_index,
  output logic [31:0]      o_pos
);
  logic [2:0] lv;

  assign o_touch_a = lv[0];
  assign o_touch_b = lv[1];
  assign o_index   = lv[2];

  initial begin
    lv    = 3'h0;
    o_pos = 32'h0;
  end

  task automatic levels(input logic [2:0] v);
    lv <= v;
  endtask

  // Six cycles a level, well past the two-flop sync, so no edge is lost
  task automatic pulse(input logic [2:0] m, input logic [31:0] p_hi, input logic [31:0] p_lo);
    o_pos <= p_hi;
    lv    <= m;
    repeat (6) @(posedge i_clk);
    o_pos <= p_lo;
    lv    <= 3'h0;
    repeat (6) @(posedge i_clk);
  endtask
endmodule

// ===== test/testbench.sv
`timescale 1ns/1ps

module testbench
  import tppl_pkg::*;
;
  logic                   clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
  logic [TPPL_ADDR_W-1:0] awaddr, araddr;
  logic [31:0]            wdata;
  logic [3:0]             wstrb;
  wire                    ta, tb, zi, awready, wready, bvalid, arready, rvalid, irq;
  wire  [31:0]            pos, rdata;
  wire  [1:0]             bresp, rresp;
  int                     n_errors = 0;
  int                     compares = 0;
  int                     cycles = 0;

  tppl_sensor_model sens (.i_clk(clk), .o_touch_a(ta), .o_touch_b(tb), .o_index(zi), .o_pos(pos));

  tppl_probe_latch dut (
    .I_SYS_CLK(clk), .I_RST_B(rst_b), .I_TOUCH_INPUT_A(ta), .I_TOUCH_INPUT_B(tb),
    .I_ENC_INDEX(zi), .I_POSITION(pos), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_AWADDR(awaddr), .I_WVALID(wvalid), .O_WREADY(wready), .I_WDATA(wdata),
    .I_WSTRB(wstrb), .O_BVALID(bvalid), .I_BREADY(bready), .O_BRESP(bresp),
    .I_ARVALID(arvalid), .O_ARREADY(arready), .I_ARADDR(araddr), .O_RVALID(rvalid),
    .I_RREADY(rready), .O_RDATA(rdata), .O_RRESP(rresp), .O_IRQ(irq)
  );

  // --------------------
  // Checking and closing
  // --------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (n_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // --------------------
  // Bus cycles
  // --------------------
  // Nonblocking drives on the rising edge keep a strobe from being driven twice in one step
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= {idx, 2'h0};
    wdata <= d;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (bvalid === 1'b1) break;
      if (aw && awready === 1'b1) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, RESP_OKAY});
    @(posedge clk);
  endtask

  task automatic rd(input logic [15:0] idx, input logic [31:0] exp, input logic [1:0] er);
    arvalid <= 1'b1;
    araddr <= {idx, 2'h0};
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (rvalid === 1'b1) break;
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, er});
    @(posedge clk);
  endtask

  // --------------------
  // Scenarios
  // --------------------
  task automatic t_reset();
    rd(IDX_POL_ONE, 32'h1, RESP_OKAY);
    rd(IDX_POL_TWO, 32'h1, RESP_OKAY);
    rd(IDX_CTRL, 32'h0, RESP_OKAY);
    rd(IDX_STAT, 32'h0, RESP_OKAY);
    rd(IDX_POS_2F, 32'h0, RESP_OKAY);
    rd(IDX_CNT_1R, 32'h0, RESP_OKAY);
    rd(16'h7000, 32'h0, RESP_SLVERR);
    wr(IDX_POS_1R, 32'h12345678);
    rd(IDX_POS_1R, 32'h0, RESP_OKAY);
  endtask

  task automatic t_dig();
    sens.levels(3'h1);
    repeat (4) @(posedge clk);
    rd(IDX_DIG_IN, 32'h04000000, RESP_OKAY);
    sens.levels(3'h2);
    repeat (4) @(posedge clk);
    rd(IDX_DIG_IN, 32'h08000000, RESP_OKAY);
    sens.levels(3'h0);
    repeat (4) @(posedge clk);
  endtask

  task automatic t_single();
    wr(IDX_IRQ_MASK, 32'h1);
    wr(IDX_CTRL, 32'h0011);
    rd(IDX_STAT, 32'h0001, RESP_OKAY);
    sens.pulse(3'h1, 32'h80000000, 32'h1);
    rd(IDX_POS_1R, 32'h80000000, RESP_OKAY);
    rd(IDX_POS_1F, 32'h0, RESP_OKAY);
    rd(IDX_STAT, 32'h0003, RESP_OKAY);
    chk({31'h0, irq}, 32'h1);
    rd(IDX_IRQ_STAT, 32'h1, RESP_OKAY);
    sens.pulse(3'h1, 32'h5, 32'h6);
    rd(IDX_POS_1R, 32'h80000000, RESP_OKAY);
    rd(IDX_CNT_1R, 32'h1, RESP_OKAY);
    wr(IDX_IRQ_MASK, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(IDX_IRQ_STAT, 32'h1);
    rd(IDX_IRQ_STAT, 32'h0, RESP_OKAY);
    wr(IDX_CTRL, 32'h0030);
    wr(IDX_CTRL, 32'h0031);
    rd(IDX_CNT_1R, 32'h0, RESP_OKAY);
    rd(IDX_STAT, 32'h0001, RESP_OKAY);
    sens.pulse(3'h1, 32'h7FFFFFFF, 32'h2);
    rd(IDX_POS_1R, 32'h7FFFFFFF, RESP_OKAY);
    rd(IDX_CNT_1F, 32'h0, RESP_OKAY);
  endtask

  task automatic t_cont();
    wr(IDX_CTRL, 32'h3300);
    sens.pulse(3'h2, 32'h10, 32'h20);
    sens.pulse(3'h2, 32'hFFFFFFF0, 32'h40);
    sens.pulse(3'h1, 32'h50, 32'h60);
    // Input B is inverted by the default polarity: pin fall is a rise
    rd(IDX_POS_2R, 32'h40, RESP_OKAY);
    rd(IDX_POS_2F, 32'hFFFFFFF0, RESP_OKAY);
    rd(IDX_CNT_2R, 32'h2, RESP_OKAY);
    rd(IDX_CNT_2F, 32'h2, RESP_OKAY);
    rd(IDX_STAT, 32'h0700, RESP_OKAY);
  endtask

  task automatic t_index();
    wr(IDX_CTRL, 32'h0037);
    sens.pulse(3'h1, 32'h99, 32'h98);
    sens.pulse(3'h4, 32'hA, 32'hB);
    rd(IDX_POS_1R, 32'hA, RESP_OKAY);
    rd(IDX_POS_1F, 32'hB, RESP_OKAY);
    rd(IDX_CNT_1R, 32'h1, RESP_OKAY);
    rd(IDX_STAT, 32'h0007, RESP_OKAY);
    wr(IDX_CTRL, 32'h1700);
    sens.pulse(3'h4, 32'hC, 32'hD);
    rd(IDX_POS_2R, 32'hC, RESP_OKAY);
    rd(IDX_POS_2F, 32'hFFFFFFF0, RESP_OKAY);
    rd(IDX_CNT_2F, 32'h0, RESP_OKAY);
  endtask

  task automatic t_pol();
    wr(IDX_CTRL, 32'h0);
    wr(IDX_POL_ONE, 32'h2);
    wr(IDX_CTRL, 32'h1111);
    sens.pulse(3'h3, 32'h11, 32'h22);
    rd(IDX_POS_1R, 32'h22, RESP_OKAY);
    rd(IDX_POS_2R, 32'h11, RESP_OKAY);
  endtask

  // --------------------
  // Clock, reset, sequence
  // --------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_errors++;
      stop_test();
    end
  end

  initial begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    awaddr = '0;
    araddr = '0;
    wdata = 32'h0;
    wstrb = 4'hF;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_dig();
    t_single();
    t_cont();
    t_index();
    t_pol();
    stop_test();
  end
endmodule
